//--- design/pdtg_pkg.sv
// constants and types of the prescaler, divider and timing generator
// Functional notes
// - three-stage prescaler, 21-stage divider, main clock and cycle counter
// - stage one takes fc/4 when its select is 0, fc/8 when 1
// - prescaler and divider clear on reset, stop entry and stop exit
// - tap n gives fc over 2^(n+2), or 2^(n+3) with stage-one select set
// - stage seven input chosen by clock select, stage-seven select and warm-up
// - slow modes or stage-seven select 1 feed stage seven from fs
// - slow modes stop stage-one input, freezing taps one to six
// - warm-up after stop from full speed feeds stage seven from stage six
// - bits four and three of divider select read as don't care
// - stage-seven select sits at bit four of timebase divider control
// - a machine cycle is four states, each one main clock long
// - instructions last one to ten machine cycles
// - single-clock operation: machine cycle is four fc periods
// - main clock source select switches main clock between fc and fs
package pdtg_pkg;
    localparam int PRE_STAGES = 3;
    localparam int DIV_STAGES = 21;
    localparam int LOW_STAGES = 6;
    localparam int MC_MAX = 10;
    localparam int ADDR_W = 12;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_DIV_SEL = 8'h30;
    localparam logic [7:0] IDX_TB_CTRL = 8'h36;
    localparam logic [7:0] IDX_SYS_CTRL2 = 8'h38;
    localparam logic [7:0] IDX_DIV_STAT = 8'h3A;
    localparam logic [ADDR_W-1:0] ADDR_DIV_SEL = {2'h0, IDX_DIV_SEL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_TB_CTRL = {2'h0, IDX_TB_CTRL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_SYS_CTRL2 = {2'h0, IDX_SYS_CTRL2, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_DIV_STAT = {2'h0, IDX_DIV_STAT, 2'h0};
    // field positions
    localparam int STAGE_ONE_SEL_BIT = 5;
    localparam int STAGE_SEVEN_SEL_BIT = 4;
    localparam int MAIN_SRC_SEL_BIT = 0;
    // reset values
    localparam logic [7:0] TB_CTRL_RST = 8'h00;
    localparam logic STAGE_ONE_SEL_RST = 1'b0;
    localparam logic MAIN_SRC_SEL_RST = 1'b0;
    // prescaler counts at which stage one is fed
    localparam logic [1:0] PRE_DIV4_LAST = 2'h3;
    localparam logic [2:0] PRE_DIV8_LAST = 3'h7;
    typedef enum logic [1:0] {
        state_zero,
        state_one,
        state_two,
        state_three
    } pdtg_mstate_type;
    function automatic logic [7:0] pdtg_bit8(input int pos, input logic v);
        logic [7:0] r;
        r = 8'h00;
        r[pos] = v;
        return r;
    endfunction
endpackage

//--- design/pdtg_top.sv
// prescaler, 21-stage divider, main clock and machine cycle sequencer
`timescale 1ns/1ps
module pdtg_top
    import pdtg_pkg::*;
#(
    parameter int DIV_W = DIV_STAGES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // low-frequency clock pin
    input wire logic low_freq_clock,
    // operating mode controller
    input wire logic stop_entry,
    input wire logic stop_exit,
    input wire logic warm_up,
    // instruction timing
    input wire logic instr_start,
    input wire logic [3:0] instr_cycles,
    // timing outputs
    output logic [DIV_W-1:0] divider_taps,
    output logic [PRE_STAGES-1:0] prescaler_taps,
    output logic main_clk_tick,
    output pdtg_mstate_type machine_state,
    output logic machine_cycle_end,
    output logic instr_done
);
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic fs_s1;
        logic fs_s2;
        logic fs_s3;
        logic fs_lvl;
        logic stage_one_sel;
        logic [7:0] tb_ctrl;
        logic main_src_sel;
        logic stopped;
        logic from_full;
        logic [PRE_STAGES-1:0] pre;
        logic [DIV_W-1:0] dv;
        logic mclk;
        pdtg_mstate_type mst;
        logic mc_end;
        logic [3:0] icnt;
        logic ibusy;
        logic idone;
    } pdtg_state_type;

    pdtg_state_type st_ff;
    pdtg_state_type nxt_st;

    logic fs_tick;
    logic slow;
    logic stage_seven_sel;
    logic stage_one_in;
    logic stage_seven_in;
    logic low_carry;
    logic use_stage_six;
    logic main_tick;
    logic acc;
    logic setup;
    logic mapped;
    logic [7:0] rd_byte;

    default clocking cb_main @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    always_comb begin
        slow = st_ff.main_src_sel;
        stage_seven_sel = st_ff.tb_ctrl[STAGE_SEVEN_SEL_BIT];
        fs_tick = !st_ff.stopped && (st_ff.fs_s2 == st_ff.fs_s3)
            && st_ff.fs_s2 && !st_ff.fs_lvl;
        // stage one input: fc/4 or fc/8 from the prescaler, off when slow
        stage_one_in = !st_ff.stopped && !slow &&
            (st_ff.stage_one_sel ? (st_ff.pre == PRE_DIV8_LAST)
                : (st_ff.pre[1:0] == PRE_DIV4_LAST));
        low_carry = stage_one_in && (&st_ff.dv[LOW_STAGES-1:0]);
        // stage seven source selection
        use_stage_six = (!slow && !stage_seven_sel)
            || (warm_up && st_ff.from_full);
        stage_seven_in = use_stage_six ? low_carry : fs_tick;
        // main clock: fc in full speed, fs in slow modes
        main_tick = slow ? fs_tick : !st_ff.stopped;
        setup = psel && !penable;
        acc = psel && penable && st_ff.pready;
        mapped = (paddr == ADDR_DIV_SEL) || (paddr == ADDR_TB_CTRL)
            || (paddr == ADDR_SYS_CTRL2) || (paddr == ADDR_DIV_STAT);
        case (paddr)
            ADDR_DIV_SEL: rd_byte = pdtg_bit8(STAGE_ONE_SEL_BIT,
                st_ff.stage_one_sel);
            ADDR_TB_CTRL: rd_byte = st_ff.tb_ctrl;
            ADDR_SYS_CTRL2: rd_byte = pdtg_bit8(MAIN_SRC_SEL_BIT,
                st_ff.main_src_sel);
            ADDR_DIV_STAT: rd_byte = {4'h0, st_ff.ibusy, st_ff.stopped,
                st_ff.mst};
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        // apb: setup, then one wait, then ready
        nxt_st.pready = psel && penable && !st_ff.pready;
        nxt_st.pslverr = psel && penable && !st_ff.pready && !mapped;
        if (psel && penable && !st_ff.pready) begin
            nxt_st.prdata = (mapped && !pwrite) ? {24'h0, rd_byte} : 32'h0;
        end
        if (acc && pwrite && mapped) begin
            case (paddr)
                ADDR_DIV_SEL: nxt_st.stage_one_sel =
                    pwdata[STAGE_ONE_SEL_BIT];
                ADDR_TB_CTRL: nxt_st.tb_ctrl = pwdata[7:0];
                ADDR_SYS_CTRL2: nxt_st.main_src_sel =
                    pwdata[MAIN_SRC_SEL_BIT];
                default: nxt_st.tb_ctrl = st_ff.tb_ctrl;
            endcase
        end
        // low-frequency pin synchroniser and filtered level
        nxt_st.fs_s1 = low_freq_clock;
        nxt_st.fs_s2 = st_ff.fs_s1;
        nxt_st.fs_s3 = st_ff.fs_s2;
        if (st_ff.fs_s2 == st_ff.fs_s3) begin
            nxt_st.fs_lvl = st_ff.fs_s3;
        end
        // prescaler and divider chain
        if (!st_ff.stopped) begin
            nxt_st.pre = st_ff.pre + 1'b1;
        end
        if (stage_one_in) begin
            nxt_st.dv[LOW_STAGES-1:0] =
                st_ff.dv[LOW_STAGES-1:0] + 1'b1;
        end
        if (stage_seven_in) begin
            nxt_st.dv[DIV_W-1:LOW_STAGES] =
                st_ff.dv[DIV_W-1:LOW_STAGES] + 1'b1;
        end
        if (stop_entry) begin
            nxt_st.stopped = 1'b1;
            nxt_st.from_full = !slow;
        end
        if (stop_exit) begin
            nxt_st.stopped = 1'b0;
        end
        if (stop_entry || stop_exit) begin
            nxt_st.pre = '0;
            nxt_st.dv = '0;
        end
        // machine cycle sequencer
        nxt_st.mclk = main_tick;
        nxt_st.mc_end = 1'b0;
        nxt_st.idone = 1'b0;
        if (main_tick) begin
            case (st_ff.mst)
                state_zero: nxt_st.mst = state_one;
                state_one: nxt_st.mst = state_two;
                state_two: nxt_st.mst = state_three;
                state_three: nxt_st.mst = state_zero;
                default: nxt_st.mst = state_zero;
            endcase
            nxt_st.mc_end = (st_ff.mst == state_three);
        end
        // instruction length in machine cycles
        if (main_tick && st_ff.mst == state_three && st_ff.ibusy) begin
            if (st_ff.icnt <= 4'h1) begin
                nxt_st.ibusy = 1'b0;
                nxt_st.idone = 1'b1;
            end else begin
                nxt_st.icnt = st_ff.icnt - 1'b1;
            end
        end
        if (instr_start && !st_ff.ibusy) begin
            nxt_st.ibusy = 1'b1;
            nxt_st.icnt = (instr_cycles == 4'h0) ? 4'h1 :
                (instr_cycles > 4'(MC_MAX)) ? 4'(MC_MAX) : instr_cycles;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '{prdata: 32'h0, pready: 1'b0, pslverr: 1'b0,
                fs_s1: 1'b0, fs_s2: 1'b0, fs_s3: 1'b0, fs_lvl: 1'b0,
                stage_one_sel: STAGE_ONE_SEL_RST, tb_ctrl: TB_CTRL_RST,
                main_src_sel: MAIN_SRC_SEL_RST, stopped: 1'b0,
                from_full: 1'b0, pre: '0, dv: '0, mclk: 1'b0,
                mst: state_zero, mc_end: 1'b0, icnt: 4'h0,
                ibusy: 1'b0, idone: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign divider_taps = st_ff.dv;
    assign prescaler_taps = st_ff.pre;
    assign main_clk_tick = st_ff.mclk;
    assign machine_state = st_ff.mst;
    assign machine_cycle_end = st_ff.mc_end;
    assign instr_done = st_ff.idone;

    a_stop_clear: assert property (
        stop_entry |=> (st_ff.dv == '0 && st_ff.pre == '0))
        else $error("divider not cleared on stop");
    a_exit_clear: assert property (
        stop_exit |=>
        (st_ff.dv == '0 && st_ff.pre == '0 && !st_ff.stopped))
        else $error("divider not cleared on stop exit");
    a_stop_hold: assert property (
        (st_ff.stopped && !stop_exit) |=>
        ($stable(st_ff.dv) && $stable(st_ff.pre)))
        else $error("divider moved while stopped");
    a_pre_count: assert property (
        (!st_ff.stopped && !stop_entry && !stop_exit) |=>
        st_ff.pre == PRE_STAGES'($past(st_ff.pre) + 1'b1))
        else $error("prescaler did not count");

    a_slow_freeze: assert property (
        (slow && !stop_entry && !stop_exit) |=>
        $stable(st_ff.dv[LOW_STAGES-1:0]))
        else $error("low stages moved in slow mode");
    a_div4_feed: assert property (
        (!slow && !st_ff.stopped && !st_ff.stage_one_sel && !stop_entry
        && !stop_exit && st_ff.pre[1:0] == PRE_DIV4_LAST) |=>
        st_ff.dv[0] != $past(st_ff.dv[0]))
        else $error("stage one not fed at fc/4");
    a_div8_feed: assert property (
        (!slow && !st_ff.stopped && st_ff.stage_one_sel && !stop_entry
        && !stop_exit && st_ff.pre == PRE_DIV8_LAST) |=>
        st_ff.dv[0] != $past(st_ff.dv[0]))
        else $error("stage one not fed at fc/8");
    a_div8_hold: assert property (
        (st_ff.stage_one_sel && st_ff.pre != PRE_DIV8_LAST && !stop_entry
        && !stop_exit) |=> $stable(st_ff.dv[LOW_STAGES-1:0]))
        else $error("stage one fed early at fc/8");

    a_seven_from_six: assert property (
        (low_carry && use_stage_six && !stop_entry && !stop_exit) |=>
        st_ff.dv[LOW_STAGES] != $past(st_ff.dv[LOW_STAGES]))
        else $error("stage seven missed stage six carry");
    a_seven_from_fs: assert property (
        (!use_stage_six && !fs_tick && !stop_entry && !stop_exit) |=>
        $stable(st_ff.dv[DIV_W-1:LOW_STAGES]))
        else $error("upper stages moved without fs edge");
    a_seven_fs_feed: assert property (
        (!use_stage_six && fs_tick && !stop_entry && !stop_exit) |=>
        st_ff.dv[LOW_STAGES] != $past(st_ff.dv[LOW_STAGES]))
        else $error("stage seven missed fs edge");
    a_warm_route: assert property (
        (warm_up && st_ff.from_full && low_carry && !stop_entry
        && !stop_exit) |=>
        st_ff.dv[LOW_STAGES] != $past(st_ff.dv[LOW_STAGES]))
        else $error("warm-up not routed from stage six");
    a_lvl_agree: assert property (
        (st_ff.fs_s2 != st_ff.fs_s3) |=>
        st_ff.fs_lvl == $past(st_ff.fs_lvl))
        else $error("fs level taken before flops agree");

    a_state_walk: assert property (
        (main_tick && st_ff.mst == state_three) |=>
        (st_ff.mst == state_zero && st_ff.mc_end))
        else $error("machine cycle did not wrap after four states");
    a_full_speed_cycle: assert property (
        (!slow && !st_ff.stopped && st_ff.mst == state_zero) |=>
        (st_ff.mst == state_one && st_ff.mclk))
        else $error("full speed state not one fc period");
    a_slow_tick: assert property (
        (slow && !fs_tick) |=> !st_ff.mclk)
        else $error("main tick in slow mode without fs edge");
    a_instr_len: assert property (
        st_ff.idone |->
        (st_ff.mc_end && !st_ff.ibusy && $past(st_ff.ibusy)))
        else $error("instruction done without busy count");
    a_done_pulse: assert property (
        st_ff.idone |=> !st_ff.idone)
        else $error("instruction done longer than one cycle");

    a_src_write: assert property (
        (acc && pwrite && paddr == ADDR_SYS_CTRL2) |=>
        slow == $past(pwdata[MAIN_SRC_SEL_BIT]))
        else $error("main clock source select not written");
    a_seven_sel_bit: assert property (
        (acc && pwrite && paddr == ADDR_TB_CTRL) |=>
        stage_seven_sel == $past(pwdata[STAGE_SEVEN_SEL_BIT]))
        else $error("stage-seven select not at its bit");
    a_apb_ready: assert property (
        (setup ##1 psel && penable) |=> pready)
        else $error("apb access not answered in one wait");
    a_apb_err: assert property (
        (psel && penable && !st_ff.pready && !mapped) |=>
        (pslverr && pready))
        else $error("unmapped access not flagged");

    c_stop_cycle: cover property (
        stop_entry ##[1:20] stop_exit);
    c_slow_mode: cover property (
        slow && fs_tick);
    c_instr_ten: cover property (
        instr_start && instr_cycles == 4'hA);
    c_warm_feed: cover property (
        warm_up && st_ff.from_full && low_carry);
    c_div8_feed: cover property (
        st_ff.stage_one_sel && stage_one_in);
endmodule

//--- test/tb_top.sv
// self-checking bench of the prescaler, divider and timing generator
`timescale 1ns/1ps
module tb_top;
    import pdtg_pkg::*;
    localparam int FS_PER = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic low_freq_clock = 1'b0;
    logic stop_entry = 1'b0;
    logic stop_exit = 1'b0;
    logic warm_up = 1'b0;
    logic instr_start = 1'b0;
    logic [3:0] instr_cycles = 4'h1;
    logic [31:0] prdata;
    logic pready, pslverr, main_clk_tick, machine_cycle_end, instr_done;
    logic [DIV_STAGES-1:0] divider_taps;
    logic [PRE_STAGES-1:0] prescaler_taps;
    pdtg_mstate_type machine_state;
    int fs_cnt = 0;
    int checks = 0;
    int mismatches = 0;
    pdtg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .low_freq_clock(low_freq_clock), .stop_entry(stop_entry),
        .stop_exit(stop_exit), .warm_up(warm_up), .instr_start(instr_start),
        .instr_cycles(instr_cycles), .divider_taps(divider_taps),
        .prescaler_taps(prescaler_taps), .main_clk_tick(main_clk_tick),
        .machine_state(machine_state),
        .machine_cycle_end(machine_cycle_end), .instr_done(instr_done));
    always #25 pclk = ~pclk;
    // slow clock made on the bench clock edge
    always @(posedge pclk) begin
        fs_cnt <= (fs_cnt == FS_PER / 2 - 1) ? 0 : fs_cnt + 1;
        if (fs_cnt == FS_PER / 2 - 1) begin
            low_freq_clock <= ~low_freq_clock;
        end
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [7:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) mismatches++;
    endtask
    function automatic logic pick(input int k);
        if (k < DIV_STAGES) return divider_taps[k];
        if (k == 21) return main_clk_tick;
        return machine_cycle_end;
    endfunction
    task automatic wait_rise(input int k, output int c);
        logic prev;
        logic hit;
        prev = pick(k);
        c = 0;
        do begin
            @(posedge pclk);
            c++;
            hit = (pick(k) === 1'b1) && (prev === 1'b0);
            prev = pick(k);
        end while (!hit && c < 5000);
    endtask
    task automatic period(input int k, output int p);
        wait_rise(k, p);
        wait_rise(k, p);
    endtask
    initial begin
        repeat (40000) @(posedge pclk);
        mismatches++;
        finish_test();
    end
    initial begin
        logic [31:0] rd;
        logic err;
        logic [1:0] ms;
        logic [7:0] v;
        int p, k, n, c, s1;
        rd = $urandom(32'h5bd119b5);
        repeat (12) @(posedge pclk);
        check("taps in reset", {prescaler_taps, divider_taps}, 32'h0);
        presetn <= 1'b1;
        apb(1'b0, ADDR_TB_CTRL, 8'h00, rd, err);
        check("tb ctrl reset", rd, {24'h0, TB_CTRL_RST});
        apb(1'b0, ADDR_DIV_SEL, 8'h00, rd, err);
        check("div sel reset", rd, 32'h0);
        apb(1'b0, 12'h004, 8'h00, rd, err);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        v = 8'($urandom) & 8'hEF;
        apb(1'b1, ADDR_TB_CTRL, v, rd, err);
        apb(1'b0, ADDR_TB_CTRL, 8'h00, rd, err);
        check("tb ctrl readback", rd, {24'h0, v});
        // tap rates, random taps and the stage six and seven corners
        for (int i = 0; i < 7; i++) begin
            k = (i < 5) ? int'($urandom % 4) : i;
            s1 = (i < 5) ? int'($urandom % 2) : 6 - i;
            apb(1'b1, ADDR_DIV_SEL, 8'(s1 << 5), rd, err);
            apb(1'b0, ADDR_DIV_SEL, 8'h00, rd, err);
            check("div sel readback", rd, 32'(s1 << 5));
            period(k, p);
            check("tap period", p, 32'(1 << (k + 3 + s1)));
        end
        apb(1'b1, ADDR_DIV_SEL, 8'h00, rd, err);
        period(0, p);
        check("tap one period", p, 32'h8);
        for (int i = 0; i < 8; i++) begin
            ms = machine_state;
            @(posedge pclk);
            ms = ms + 2'h1;
            check("machine state", machine_state, ms);
        end
        period(22, p);
        check("cycle end full", p, 32'h4);
        for (int i = 0; i < 6; i++) begin
            n = (i == 0) ? 1 : (i == 1) ? 10 : 1 + int'($urandom % 10);
            @(posedge pclk);
            instr_cycles <= 4'(n);
            instr_start <= 1'b1;
            @(posedge pclk);
            instr_start <= 1'b0;
            c = 0;
            p = 0;
            do begin
                @(posedge pclk);
                p++;
                if (machine_cycle_end === 1'b1 && p > 1) c++;
            end while (instr_done !== 1'b1 && p < 200);
            check("instr cycles", c, n);
        end
        apb(1'b1, ADDR_TB_CTRL, 8'h10, rd, err);
        period(6, p);
        check("tap seven from fs", p, 2 * FS_PER);
        @(posedge pclk);
        stop_entry <= 1'b1;
        @(posedge pclk);
        stop_entry <= 1'b0;
        @(posedge pclk);
        check("stop entry clear", {prescaler_taps, divider_taps}, 0);
        apb(1'b0, ADDR_DIV_STAT, 8'h00, rd, err);
        check("status stopped", rd[3:2], 32'h1);
        repeat (20) @(posedge pclk);
        check("stop frozen", {prescaler_taps, divider_taps}, 0);
        stop_exit <= 1'b1;
        warm_up <= 1'b1;
        @(posedge pclk);
        stop_exit <= 1'b0;
        @(posedge pclk);
        check("stop exit clear", {prescaler_taps, divider_taps}, 0);
        period(6, p);
        check("warm up tap seven", p, 32'd512);
        warm_up <= 1'b0;
        period(6, p);
        check("tap seven after", p, 2 * FS_PER);
        apb(1'b1, ADDR_TB_CTRL, 8'h00, rd, err);
        apb(1'b1, ADDR_SYS_CTRL2, 8'h01, rd, err);
        repeat (4) @(posedge pclk);
        v = {2'h0, divider_taps[5:0]};
        repeat (60) @(posedge pclk);
        check("slow low taps", {2'h0, divider_taps[5:0]}, v);
        period(6, p);
        check("slow tap seven", p, 2 * FS_PER);
        period(21, p);
        check("slow main tick", p, FS_PER);
        period(22, p);
        check("slow cycle end", p, 4 * FS_PER);
        apb(1'b1, ADDR_SYS_CTRL2, 8'h00, rd, err);
        period(0, p);
        check("back to full", p, 32'h8);
        finish_test();
    end
endmodule
